// ### hw/pscr_pkg.sv
// pscr_pkg: register indices, field positions, reset values and timing
// assumes: 200 MHz clk, registers reached by word index over ahb-lite
package pscr_pkg;
  // register indices, byte address is four times the index
  localparam logic [29:0] IDX_SLEW_LO = 30'h414;
  localparam logic [29:0] IDX_SLEW_HI = 30'h415;
  localparam logic [29:0] IDX_DEMAP_CTL = 30'h416;
  localparam logic [29:0] IDX_SAMP_LO = 30'h417;
  localparam logic [29:0] IDX_SAMP_HI = 30'h418;
  localparam logic [29:0] IDX_SETP_LO = 30'h419;
  localparam logic [29:0] IDX_SETP_HI = 30'h41a;
  localparam logic [29:0] IDX_GAIN_B0 = 30'h41b;
  localparam logic [29:0] IDX_GAIN_B1 = 30'h41c;
  localparam logic [29:0] IDX_GAIN_B2 = 30'h41d;
  localparam logic [29:0] IDX_CLAMP = 30'h41e;
  localparam logic [29:0] IDX_PUMP = 30'h430;
  localparam logic [29:0] IDX_FBDIV = 30'h431;
  localparam logic [29:0] IDX_FILTER = 30'h432;
  localparam logic [29:0] IDX_PREDIV = 30'h433;
  // reset values
  localparam logic [6:0] PUMP_RST = 7'h2e;
  localparam logic [7:0] FILTER_RST = 8'h7f;
  // field positions
  localparam int DEMAP_EN_BIT = 0;
  localparam int PREDIV_RST_BIT = 1;
  localparam int RZ_BYPASS_BIT = 0;
  localparam int RP2_LSB = 6;
  localparam int RZ_LSB = 3;
  localparam int CP1_LSB = 0;
  // divider range that software must keep to
  localparam logic [7:0] FBDIV_MIN = 8'h0e;
  localparam logic [7:0] FBDIV_MAX = 8'hff;
  // smallest useful nonzero slew limit, us/s
  localparam logic [15:0] SLEW_MIN_USEFUL = 16'h0064;
  // timing: a limit of n us/s is n ps of phase per microsecond
  localparam int CLK_PERIOD_PS = 5000;
  localparam int US_PS = 1000000;
  localparam int CYCLES_PER_US = US_PS / CLK_PERIOD_PS;
  localparam int PHASE_W = 30;
  // ahb transfer types
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### hw/pscr_ahb_front.sv
// pscr_ahb_front: ahb-lite address phase capture for a zero-wait slave
// assumes: single slave, hready is the slave's own hreadyout
`timescale 1ns/1ps
module pscr_ahb_front (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // decoded accesses
  output logic rd_req,
  output logic [29:0] rd_idx,
  output logic wr_stb,
  output logic [29:0] wr_idx
);
  import pscr_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [29:0] idx;
  } pscr_front_type;

  pscr_front_type s_ff, nxt_s;
  logic take;

  // htrans[1] covers nonseq and seq, idle and busy are ignored
  assign take = hsel & hready & htrans[1];
  assign rd_req = take & ~hwrite;
  assign rd_idx = haddr[31:2];
  assign wr_stb = s_ff.wr_pend & hready; // data phase ends on hready
  assign wr_idx = s_ff.idx;

  // remember a write until its data phase
  always_comb begin
    nxt_s = s_ff;
    if (hready) begin
      nxt_s.wr_pend = take & hwrite;
      nxt_s.idx = haddr[31:2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // pscr_ahb_front

// ### hw/pscr_slew.sv
// pscr_slew: moves the loop phase toward its target at a capped rate
// assumes: target comes from same-clock logic, signed picoseconds
`timescale 1ns/1ps
module pscr_slew #(
  parameter int TICK_CYCLES = pscr_pkg::CYCLES_PER_US
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [pscr_pkg::PHASE_W-1:0] target,
  input wire logic [15:0] limit,
  // result
  output logic [pscr_pkg::PHASE_W-1:0] phase,
  output logic slewing
);
  import pscr_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [TW-1:0] tick;
    logic [PHASE_W-1:0] phase;
  } pscr_slew_type;

  pscr_slew_type s_ff, nxt_s;
  logic signed [PHASE_W:0] diff;
  logic [PHASE_W:0] mag;
  logic [PHASE_W:0] lim_w;

  assign diff = $signed({target[PHASE_W-1], target}) - $signed({s_ff.phase[PHASE_W-1], s_ff.phase});
  assign mag = diff[PHASE_W] ? (PHASE_W+1)'(-diff) : diff;
  assign lim_w = (PHASE_W+1)'(limit);
  assign phase = s_ff.phase;
  assign slewing = (limit != 16'h0000) && (diff != '0);

  // one step of at most limit ps per microsecond tick
  always_comb begin
    nxt_s = s_ff;
    if (s_ff.tick == TW'(TICK_CYCLES - 1)) begin
      nxt_s.tick = '0;
    end else begin
      nxt_s.tick = s_ff.tick + 1'b1;
    end
    if (limit == 16'h0000) begin
      nxt_s.phase = target;
    end else if (s_ff.tick == TW'(TICK_CYCLES - 1)) begin
      if (mag <= lim_w) begin
        nxt_s.phase = target;
      end else if (diff[PHASE_W]) begin
        nxt_s.phase = s_ff.phase - PHASE_W'(limit);
      end else begin
        nxt_s.phase = s_ff.phase + PHASE_W'(limit);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // pscr_slew

// ### hw/pscr_regs.sv
// pscr_regs: loop channel slew, demapping and output loop config bank
// assumes: ahb-lite single transfers, one slave, same clock as logic
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pscr_regs #(
  parameter int TICK_CYCLES = pscr_pkg::CYCLES_PER_US
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // fixed phase offset from the offset registers, signed ps
  input wire logic [pscr_pkg::PHASE_W-1:0] phase_offset_target,
  // digital loop outputs
  output logic [pscr_pkg::PHASE_W-1:0] digital_loop_zero_phase,
  output logic digital_loop_zero_slewing,
  // demapping controller
  output logic demap_enable,
  output logic [15:0] demap_sampled_addr,
  output logic [15:0] demap_setpoint_addr,
  output logic [23:0] demap_gain,
  output logic [7:0] demap_clamp,
  // output analog loop
  output logic [6:0] pump_current_code,
  output logic [7:0] output_loop_feedback_divider,
  output logic feedback_divider_in_range,
  output logic [1:0] second_pole_resistor_sel,
  output logic [2:0] loop_zero_resistor_sel,
  output logic [2:0] first_pole_capacitor_sel,
  output logic output_pre_divider_reset,
  output logic loop_zero_resistor_bypass
);
  import pscr_pkg::*;

  typedef struct packed {
    logic [15:0] slew;
    logic demap_en;
    logic [15:0] samp;
    logic [15:0] setp;
    logic [23:0] gain;
    logic [7:0] clamp;
    logic [6:0] pump;
    logic [7:0] fbdiv;
    logic [7:0] filter;
    logic prediv_rst;
    logic rz_bypass;
    logic [7:0] rdata;
  } pscr_bank_type;

  pscr_bank_type s_ff, nxt_s;
  logic rd_req;
  logic [29:0] rd_idx;
  logic wr_stb;
  logic [29:0] wr_idx;
  logic [7:0] wbyte;

  // read view of one register; unmapped and reserved bits give zero
  function automatic logic [7:0] rd_byte(input logic [29:0] idx,
                                         input pscr_bank_type b);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_SLEW_LO: v = b.slew[7:0];
      IDX_SLEW_HI: v = b.slew[15:8];
      IDX_DEMAP_CTL: v = {7'h00, b.demap_en};
      IDX_SAMP_LO: v = b.samp[7:0];
      IDX_SAMP_HI: v = b.samp[15:8];
      IDX_SETP_LO: v = b.setp[7:0];
      IDX_SETP_HI: v = b.setp[15:8];
      IDX_GAIN_B0: v = b.gain[7:0];
      IDX_GAIN_B1: v = b.gain[15:8];
      IDX_GAIN_B2: v = b.gain[23:16];
      IDX_CLAMP: v = b.clamp;
      IDX_PUMP: v = {1'b0, b.pump};
      IDX_FBDIV: v = b.fbdiv;
      IDX_FILTER: v = b.filter;
      IDX_PREDIV: v = {6'h00, b.prediv_rst, b.rz_bypass};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // address phase capture
  pscr_ahb_front u_front (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .rd_req(rd_req),
    .rd_idx(rd_idx),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx)
  );

  // rate capped phase; the target is the fixed closed loop offset
  pscr_slew #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_slew (
    .clk(clk),
    .rst_n(rst_n),
    .target(phase_offset_target),
    .limit(s_ff.slew),
    .phase(digital_loop_zero_phase),
    .slewing(digital_loop_zero_slewing)
  );

  // zero wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, s_ff.rdata};
  assign wbyte = hwdata[7:0];

  // register outputs
  assign demap_enable = s_ff.demap_en;
  assign demap_sampled_addr = s_ff.samp;
  assign demap_setpoint_addr = s_ff.setp;
  assign demap_gain = s_ff.gain;
  assign demap_clamp = s_ff.clamp;
  assign pump_current_code = s_ff.pump;
  assign output_loop_feedback_divider = s_ff.fbdiv;
  // only a flag: software owns keeping the ratio legal
  assign feedback_divider_in_range = (s_ff.fbdiv >= FBDIV_MIN)
                                   && (s_ff.fbdiv <= FBDIV_MAX);
  assign second_pole_resistor_sel = s_ff.filter[RP2_LSB +: 2];
  assign loop_zero_resistor_sel = s_ff.filter[RZ_LSB +: 3];
  assign first_pole_capacitor_sel = s_ff.filter[CP1_LSB +: 3];
  assign output_pre_divider_reset = s_ff.prediv_rst;
  assign loop_zero_resistor_bypass = s_ff.rz_bypass;

  // write first, then read from the updated copy so that a read right
  // after a write to the same byte sees the new value
  always_comb begin
    nxt_s = s_ff;
    if (wr_stb) begin
      unique case (wr_idx)
        IDX_SLEW_LO: nxt_s.slew[7:0] = wbyte;
        IDX_SLEW_HI: nxt_s.slew[15:8] = wbyte;
        IDX_DEMAP_CTL: nxt_s.demap_en = wbyte[DEMAP_EN_BIT];
        IDX_SAMP_LO: nxt_s.samp[7:0] = wbyte;
        IDX_SAMP_HI: nxt_s.samp[15:8] = wbyte;
        IDX_SETP_LO: nxt_s.setp[7:0] = wbyte;
        IDX_SETP_HI: nxt_s.setp[15:8] = wbyte;
        IDX_GAIN_B0: nxt_s.gain[7:0] = wbyte;
        IDX_GAIN_B1: nxt_s.gain[15:8] = wbyte;
        IDX_GAIN_B2: nxt_s.gain[23:16] = wbyte;
        IDX_CLAMP: nxt_s.clamp = wbyte;
        IDX_PUMP: nxt_s.pump = wbyte[6:0];
        IDX_FBDIV: nxt_s.fbdiv = wbyte;
        IDX_FILTER: nxt_s.filter = wbyte;
        IDX_PREDIV: begin
          nxt_s.prediv_rst = wbyte[PREDIV_RST_BIT];
          nxt_s.rz_bypass = wbyte[RZ_BYPASS_BIT];
        end
        default: nxt_s.rdata = s_ff.rdata; // unmapped write is dropped
      endcase
    end
    if (rd_req) begin
      nxt_s.rdata = rd_byte(rd_idx, nxt_s);
    end
  end

  // synchronous reset to documented defaults
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // one assignment, so no field is driven twice in the reset step
      s_ff <= '{pump: PUMP_RST, filter: FILTER_RST, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // checks on the bank and the slew path
  property p_reset_vals;
    @(posedge clk) !rst_n |=> (pump_current_code == PUMP_RST)
      && (s_ff.filter == FILTER_RST) && (s_ff.slew == 16'h0000)
      && !demap_enable && (demap_gain == 24'h000000);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register defaults wrong after reset");

  property p_slew_bytes;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_SLEW_HI)
      |=> s_ff.slew[15:8] == $past(hwdata[7:0]) && $stable(s_ff.slew[7:0]);
  endproperty
  a_slew_bytes: assert property (p_slew_bytes)
    else $error("slew limit high byte not written alone");

  property p_step_cap;
    @(posedge clk) disable iff (!rst_n)
      ($past(s_ff.slew) != 16'h0000) && $past(rst_n)
      |-> (($past(digital_loop_zero_phase) - digital_loop_zero_phase)
           <= PHASE_W'($past(s_ff.slew))
        || (digital_loop_zero_phase - $past(digital_loop_zero_phase))
           <= PHASE_W'($past(s_ff.slew)));
  endproperty
  a_step_cap: assert property (p_step_cap)
    else $error("phase step exceeds slew limit");

  property p_no_limit;
    @(posedge clk) disable iff (!rst_n)
      s_ff.slew == 16'h0000 ##1 s_ff.slew == 16'h0000
      |-> digital_loop_zero_phase == $past(phase_offset_target);
  endproperty
  a_no_limit: assert property (p_no_limit)
    else $error("zero limit did not pass phase through");

  property p_demap_ctl;
    @(posedge clk) disable iff (!rst_n)
      rd_req && (rd_idx == IDX_DEMAP_CTL) && !wr_stb
      |=> hrdata == {31'h00000000, demap_enable};
  endproperty
  a_demap_ctl: assert property (p_demap_ctl)
    else $error("demap control reserved bits not zero");

  property p_gain_write;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_GAIN_B2)
      |=> demap_gain[23:16] == $past(hwdata[7:0])
      ##1 ($stable(demap_gain) || $past(wr_stb));
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain top byte not stored");

  property p_pump_rsvd;
    @(posedge clk) disable iff (!rst_n)
      rd_req && (rd_idx == IDX_PUMP)
      |=> hrdata[7] == 1'b0 && hrdata[6:0] == pump_current_code;
  endproperty
  a_pump_rsvd: assert property (p_pump_rsvd)
    else $error("pump current readback wrong");

  property p_fbdiv_flag;
    @(posedge clk) disable iff (!rst_n)
      feedback_divider_in_range == (output_loop_feedback_divider > 8'h0d);
  endproperty
  a_fbdiv_flag: assert property (p_fbdiv_flag)
    else $error("divider range flag wrong");

  property p_filter_map;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_FILTER)
      |=> {second_pole_resistor_sel, loop_zero_resistor_sel,
           first_pole_capacitor_sel} == $past(hwdata[7:0]);
  endproperty
  a_filter_map: assert property (p_filter_map)
    else $error("filter select fields misplaced");

  property p_prediv;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_PREDIV)
      |=> output_pre_divider_reset == $past(hwdata[1])
        && loop_zero_resistor_bypass == $past(hwdata[0]);
  endproperty
  a_prediv: assert property (p_prediv)
    else $error("pre-divider control bits misplaced");

  property p_readback;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_CLAMP) ##0 (rd_req && rd_idx == IDX_CLAMP)
      |=> hrdata == {24'h000000, $past(hwdata[7:0])};
  endproperty
  a_readback: assert property (p_readback)
    else $error("read after write returned stale byte");

  property p_okay;
    @(posedge clk) disable iff (!rst_n)
      hreadyout && !hresp && hrdata[31:8] == 24'h000000;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not okay or upper bits set");

  // byte placement and reserved bits of the remaining registers
  property p_samp_bytes;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_SAMP_LO)
      |=> demap_sampled_addr[7:0] == $past(hwdata[7:0])
        && $stable(demap_sampled_addr[15:8]);
  endproperty
  a_samp_bytes: assert property (p_samp_bytes)
    else $error("sampled address low byte not written alone");

  property p_setp_bytes;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_SETP_HI)
      |=> demap_setpoint_addr[15:8] == $past(hwdata[7:0])
        && $stable(demap_setpoint_addr[7:0]);
  endproperty
  a_setp_bytes: assert property (p_setp_bytes)
    else $error("set point address high byte not written alone");

  property p_demap_en;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_DEMAP_CTL)
      |=> demap_enable == $past(hwdata[DEMAP_EN_BIT]);
  endproperty
  a_demap_en: assert property (p_demap_en)
    else $error("demap enable not taken from bit 0");

  property p_pump_write;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_PUMP)
      |=> pump_current_code == $past(hwdata[6:0]);
  endproperty
  a_pump_write: assert property (p_pump_write)
    else $error("pump current code not stored");

  property p_fbdiv_write;
    @(posedge clk) disable iff (!rst_n)
      wr_stb && (wr_idx == IDX_FBDIV)
      |=> output_loop_feedback_divider == $past(hwdata[7:0]);
  endproperty
  a_fbdiv_write: assert property (p_fbdiv_write)
    else $error("feedback divider not stored");

  property p_prediv_rsvd;
    @(posedge clk) disable iff (!rst_n)
      rd_req && (rd_idx == IDX_PREDIV)
      |=> hrdata[7:2] == 6'h00;
  endproperty
  a_prediv_rsvd: assert property (p_prediv_rsvd)
    else $error("pre-divider control reserved bits not zero");
endmodule // pscr_regs

// ### testbench/pscr_regs_bench.sv
// pscr_regs_bench: self-checking bench for the loop channel config bank
// assumes: pscr_regs with a short slew tick, bench acts as the one ahb-lite master
`timescale 1ns/1ps
module pscr_regs_bench;
  import pscr_pkg::*;
  localparam int TICK = 4;
  // ports of the bank
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [PHASE_W-1:0] target = 30'h0;
  logic [PHASE_W-1:0] phase;
  logic slewing;
  logic demap_enable;
  logic [15:0] samp;
  logic [15:0] setp;
  logic [23:0] gain;
  logic [7:0] clamp;
  logic [6:0] pump;
  logic [7:0] fbdiv;
  logic fb_ok;
  logic [1:0] rp2;
  logic [2:0] rz;
  logic [2:0] cp1;
  logic pre_rst;
  logic rz_byp;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  // register table: index, reset value, writable bits
  logic [29:0] idx_t [15] = '{IDX_SLEW_LO, IDX_SLEW_HI, IDX_DEMAP_CTL, IDX_SAMP_LO,
    IDX_SAMP_HI, IDX_SETP_LO, IDX_SETP_HI, IDX_GAIN_B0, IDX_GAIN_B1, IDX_GAIN_B2,
    IDX_CLAMP, IDX_PUMP, IDX_FBDIV, IDX_FILTER, IDX_PREDIV};
  logic [7:0] rst_t [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h2e, 8'h00, 8'h7f, 8'h00};
  logic [7:0] msk_t [15] = '{8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h03};

  // single slave, so its hreadyout is the bus hready
  assign hready = hreadyout;

  pscr_regs #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .phase_offset_target(target), .digital_loop_zero_phase(phase),
    .digital_loop_zero_slewing(slewing), .demap_enable(demap_enable),
    .demap_sampled_addr(samp), .demap_setpoint_addr(setp), .demap_gain(gain),
    .demap_clamp(clamp), .pump_current_code(pump), .output_loop_feedback_divider(fbdiv),
    .feedback_divider_in_range(fb_ok), .second_pole_resistor_sel(rp2),
    .loop_zero_resistor_sel(rz), .first_pole_capacitor_sel(cp1),
    .output_pre_divider_reset(pre_rst), .loop_zero_resistor_bypass(rz_byp));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one ahb-lite single transfer; waits on hready at each phase
  task automatic xfer(input logic wr, input logic [29:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "hresp");
  endtask

  task automatic wr(input logic [29:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, {24'hffffff, d}, r);
  endtask

  task automatic rd_chk(input logic [29:0] idx, input logic [7:0] exp, input string what);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    check(r, {24'h0, exp}, what);
  endtask

  task automatic t_reset_values();
    for (int i = 0; i < 15; i++) begin
      rd_chk(idx_t[i], rst_t[i], "reset value");
    end
    check(32'({pump, fbdiv}), 32'({7'h2e, 8'h00}), "pump and divider at reset");
    check(32'({rp2, rz, cp1, pre_rst, rz_byp}), 32'h0000_01fc, "filter at reset");
    check({samp, setp}, 32'h0, "demap addresses at reset");
    check({31'h0, demap_enable}, 32'h0, "demap enable at reset");
    $display("test reset_values done");
  endtask

  task automatic t_readback();
    logic [7:0] pats [2] = '{8'hff, 8'h5a};
    foreach (pats[p]) begin
      for (int i = 0; i < 15; i++) begin
        wr(idx_t[i], pats[p]);
        rd_chk(idx_t[i], pats[p] & msk_t[i], "readback");
      end
    end
    wr(30'h420, 8'hff);
    rd_chk(30'h420, 8'h00, "unmapped read");
    $display("test readback done");
  endtask

  task automatic t_fields();
    wr(IDX_SAMP_LO, 8'h34);
    wr(IDX_SAMP_HI, 8'h12);
    wr(IDX_SETP_LO, 8'h78);
    wr(IDX_SETP_HI, 8'h56);
    wr(IDX_GAIN_B0, 8'h9a);
    wr(IDX_GAIN_B1, 8'hbc);
    wr(IDX_GAIN_B2, 8'hde);
    wr(IDX_CLAMP, 8'ha7);
    wr(IDX_DEMAP_CTL, 8'h01);
    wr(IDX_FILTER, 8'h8d);
    wr(IDX_PUMP, 8'h85);
    wr(IDX_PREDIV, 8'h02); // pulse the pre-divider reset, released below
    @(posedge clk);
    check({samp, setp}, 32'h12345678, "demap addresses");
    check({gain, clamp}, 32'hdebc9aa7, "gain and clamp");
    check({31'h0, demap_enable}, 32'h1, "demap enable");
    check(32'({rp2, rz, cp1}), 32'({2'h2, 3'h1, 3'h5}), "filter fields");
    check(32'(pump), 32'h0000_0005, "pump code");
    check(32'({pre_rst, rz_byp}), 32'h0000_0002, "pre-divider held in reset");
    wr(IDX_PREDIV, 8'h01);
    wr(IDX_DEMAP_CTL, 8'h00);
    @(posedge clk);
    check(32'({pre_rst, rz_byp, demap_enable}), 32'h0000_0002, "zero resistor bypass");
    wr(IDX_FBDIV, FBDIV_MIN - 8'h01);
    @(posedge clk);
    check(32'({fbdiv, fb_ok}), 32'({8'h0d, 1'b0}), "divider below range");
    wr(IDX_FBDIV, FBDIV_MIN);
    @(posedge clk);
    check(32'({fbdiv, fb_ok}), 32'({8'h0e, 1'b1}), "divider at low bound");
    wr(IDX_FBDIV, FBDIV_MAX);
    @(posedge clk);
    check(32'({fbdiv, fb_ok}), 32'({8'hff, 1'b1}), "divider at high bound");
    $display("test fields done");
  endtask

  // a write data phase overlaps the read address phase of the same byte
  task automatic t_back_to_back();
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {IDX_CLAMP, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= 32'h0000_003c;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= HTRANS_IDLE;
    do @(posedge clk); while (hready !== 1'b1);
    check(hrdata, 32'h0000_003c, "read in write data phase");
    check(32'(clamp), 32'h0000_003c, "clamp after overlap");
    $display("test back_to_back done");
  endtask

  task automatic t_slew_off();
    wr(IDX_SLEW_LO, 8'h00);
    wr(IDX_SLEW_HI, 8'h00);
    @(posedge clk);
    target <= 30'h0001_0000;
    repeat (2) @(posedge clk);
    #1;
    check({2'h0, phase}, 32'h0001_0000, "zero limit jumps");
    check({31'h0, slewing}, 32'h0, "no slewing at zero limit");
    $display("test slew_off done");
  endtask

  // phase must walk to goal in steps of at most lim, taking nsteps ticks
  task automatic slew_walk(input logic [29:0] goal, input int lim, input int nsteps);
    logic [29:0] prev;
    int n;
    int d;
    int bad;
    @(posedge clk);
    target <= goal;
    prev = phase;
    n = 0;
    bad = 0;
    // the cap sits just past the longest legal walk for this request
    while (phase !== goal && n < nsteps * TICK + 8) begin
      @(posedge clk);
      #1;
      n = n + 1;
      d = $signed(phase - prev);
      if (d > lim || d < -lim) bad = bad + 1;
      if (phase !== goal && slewing !== 1'b1) bad = bad + 1;
      prev = phase;
    end
    check(bad, 0, "slew step size");
    check({31'h0, phase === goal}, 32'h1, "slew reaches target");
    check({31'h0, n >= (nsteps - 1) * TICK && n <= nsteps * TICK + 2}, 32'h1,
          "slew duration");
  endtask

  task automatic t_slew_on();
    wr(IDX_SLEW_HI, 8'h00);
    wr(IDX_SLEW_LO, SLEW_MIN_USEFUL[7:0]);
    slew_walk(30'h0001_0000 + 30'd1000, 100, 10);
    slew_walk(30'h0001_0000 - 30'd250, 100, 13);
    // negative target crosses zero as a signed value
    // 65286 down to -256 is 65542 ps, so 656 steps of at most 100
    slew_walk(30'h3fff_ff00, 100, 656);
    #1;
    check({31'h0, slewing}, 32'h0, "slewing clears");
    $display("test slew_on done");
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_readback();
    t_fields();
    t_back_to_back();
    t_slew_off();
    t_slew_on();
    end_of_test();
  end
endmodule // pscr_regs_bench
